//--- logic/dmace_consts.svh
// Purpose: register indices, field positions, reset values and codes
// Assumes: byte address of a register is four times its index
// Notes:   included by the engine and the checker
`ifndef DMACE_CONSTS_SVH
`define DMACE_CONSTS_SVH
`define DMACE_NCH          6
`define DMACE_IDX_SET_CLR  8'h3E
`define DMACE_IDX_PRIO_EN  8'h40
`define DMACE_IDX_INDEX    8'h41
`define DMACE_IDX_STATUS   8'h42
`define DMACE_IDX_CH_BASE  8'h48
`define DMACE_IDX_CH_LAST  8'h5F
`define DMACE_SC_SET_BIT   15
`define DMACE_PRI_LSB      8
`define DMACE_RST16        16'h0000
`define DMACE_RAM_LO       16'h0080
`define DMACE_RAM_HI       16'h7FFF
`define DMACE_MOD_HOLD     2'h0
`define DMACE_MOD_INC      2'h1
`define DMACE_MOD_DEC      2'h2
`define DMACE_MOD_IDX      2'h3
`define DMACE_MD_SRC_IO    4
`define DMACE_MD_DST_IO    5
`define DMACE_MD_SRC_EXT   6
`define DMACE_MD_DST_EXT   7
`define DMACE_RESP_OKAY    2'h0
`define DMACE_RESP_SLVERR  2'h2
`endif

//--- logic/dmace_pkg.sv
// Purpose: types shared by the channel-enable engine and its users
// Assumes: AXI4-Lite with 12-bit byte addresses and 32-bit data
// Notes:   constants live in dmace_consts.svh
package dmace_pkg;
  typedef enum logic [2:0] {
    DMACE_IDLE  = 3'b001,
    DMACE_ISSUE = 3'b010,
    DMACE_STEP  = 3'b100
  } dmace_state_e;
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } dmace_axil_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dmace_axil_rsp_s;
  typedef struct packed {
    logic [2:0]  chan;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic        src_ext;
    logic        dst_ext;
    logic [1:0]  src_blk;
    logic [1:0]  dst_blk;
  } dmace_xfer_s;
endpackage

//--- logic/dmace_top.sv
// Purpose: six-channel DMA enable control, arbitration and address stepping
// Assumes: one clock, synchronous active-low reset, AXI4-Lite register access
// Notes:   one element moves per grant whose addresses pass the map, over the xfer valid/ready handshake
`timescale 1ns/10ps
`default_nettype none
`include "dmace_consts.svh"

// What this block does
// - set/clear write with bit 15 high sets enables of selected channels
// - set/clear write with bit 15 low clears enables of selected channels
// - channels with select bit zero keep their enable unchanged
// - set/clear register is write-only; bits 14 to 6 do nothing
// - set/clear register decoded at index 0x03E
// - DMA decode ignores processor mode, data-ROM map and RAM overlay
// - internal data 0080h-7FFFh is four 8K RAM blocks; rest and I/O reserved
// - each channel holds its own high or low priority
// - equal-priority requesters are served round robin
// - source and destination step independently: inc, dec or plus index
// - completion of a block clears that channel's enable by hardware, unless a same-cycle set/clear write sets it
// - external select bits pick external space; fixed map checks each address whose own select bit is zero
module dmace_top
  import dmace_pkg::*;
(
  input  wire logic                       aclk,      // 200 MHz clock
  input  wire logic                       aresetn,   // sync reset, low
  input  wire dmace_pkg::dmace_axil_req_s axil_req,  // bus master side
  output var  dmace_pkg::dmace_axil_rsp_s axil_rsp,  // bus slave answers
  output logic                            xfer_valid, // element offered
  input  wire logic                       xfer_ready, // element taken
  output var  dmace_pkg::dmace_xfer_s     xfer,      // element addresses
  output logic [5:0]                      chan_done  // block complete pulse
);
  import dmace_pkg::*;

  // ---------------- bus slave ----------------
  logic        aw_have_q;
  logic [11:0] aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_map;
  logic        rd_map;

  // ---------------- engine state ----------------
  dmace_state_e st_q;
  logic [5:0]   en_q;
  logic [5:0]   pri_q;
  logic [15:0]  index_q;
  logic [5:0]   err_q;
  logic [2:0]   cur_q;
  logic         bad_q;
  logic [2:0]   ptr_hi_q;
  logic [2:0]   ptr_lo_q;
  dmace_xfer_s  xfer_q;
  logic [95:0]  src_all;
  logic [95:0]  dst_all;
  logic [47:0]  mode_all;
  logic [95:0]  cnt_all;
  logic [5:0]   done_clr;
  logic [5:0]   err_set;
  logic         step_ok;
  logic [3:0]   pick_hi;
  logic [3:0]   pick_lo;
  logic [3:0]   pick;
  logic [15:0]  g_src;
  logic [15:0]  g_dst;
  logic [7:0]   g_mode;
  logic         g_src_ok;
  logic         g_dst_ok;
  logic         sc_wr;
  logic         pe_wr;

  function automatic logic [7:0] idx_of(input logic [11:0] a);
    return a[9:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[11:10] == 2'h0) &&
           ((i == `DMACE_IDX_SET_CLR) || (i == `DMACE_IDX_PRIO_EN) ||
            (i == `DMACE_IDX_INDEX) || (i == `DMACE_IDX_STATUS) ||
            ((i >= `DMACE_IDX_CH_BASE) && (i <= `DMACE_IDX_CH_LAST)));
  endfunction

  // byte-lane merge for the low 16 bits
  function automatic logic [15:0] wmask(input logic [15:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  s);
    return {s[1] ? nw[15:8] : old[15:8], s[0] ? nw[7:0] : old[7:0]};
  endfunction

  // round robin: first requester at or after the pointer
  function automatic logic [3:0] rr_pick(input logic [5:0] req,
                                          input logic [2:0] ptr);
    logic [3:0] r;
    int         t;
    r = 4'h0;
    t = 0;
    for (int j = `DMACE_NCH - 1; j >= 0; j--) begin
      t = int'(ptr) + j;
      if (t >= `DMACE_NCH) begin
        t = t - `DMACE_NCH;
      end
      if (req[t]) begin
        r = {1'b1, 3'(t)};
      end
    end
    return r;
  endfunction

  // fixed internal map, no mode or overlay terms
  function automatic logic map_ok(input logic [15:0] a,
                                  input logic        ext,
                                  input logic        io);
    if (ext) begin
      return 1'b1;
    end
    return !io && (a >= `DMACE_RAM_LO) && (a <= `DMACE_RAM_HI);
  endfunction

  function automatic logic [15:0] next_addr(input logic [15:0] a,
                                            input logic [1:0]  m,
                                            input logic [15:0] ix);
    case (m)
      `DMACE_MOD_INC: return a + 16'h0001;
      `DMACE_MOD_DEC: return a - 16'h0001;
      `DMACE_MOD_IDX: return a + ix;
      default:        return a;
    endcase
  endfunction

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_fire = axil_req.arvalid && !rvalid_q;
  assign wr_idx  = idx_of(aw_addr_q);
  assign rd_idx  = idx_of(axil_req.araddr);
  assign wr_map  = is_mapped(aw_addr_q);
  assign rd_map  = is_mapped(axil_req.araddr);
  assign sc_wr   = wr_fire && wr_map && (wr_idx == `DMACE_IDX_SET_CLR) && w_strb_q[0];
  assign pe_wr   = wr_fire && wr_map && (wr_idx == `DMACE_IDX_PRIO_EN);

  always_comb begin
    axil_rsp         = '0;
    axil_rsp.awready = !aw_have_q;
    axil_rsp.wready  = !w_have_q;
    axil_rsp.bvalid  = bvalid_q;
    axil_rsp.bresp   = bresp_q;
    axil_rsp.arready = !rvalid_q;
    axil_rsp.rvalid  = rvalid_q;
    axil_rsp.rdata   = rdata_q;
    axil_rsp.rresp   = rresp_q;
  end

  // write address and data held until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end else begin
        if (!aw_have_q && axil_req.awvalid) begin
          aw_have_q <= 1'b1;
          aw_addr_q <= axil_req.awaddr;
        end
        if (!w_have_q && axil_req.wvalid) begin
          w_have_q <= 1'b1;
          w_data_q <= axil_req.wdata;
          w_strb_q <= axil_req.wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `DMACE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_map ? `DMACE_RESP_OKAY : `DMACE_RESP_SLVERR;
    end else if (axil_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read data registered; set/clear reads as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `DMACE_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_map ? `DMACE_RESP_OKAY : `DMACE_RESP_SLVERR;
      rdata_q  <= 32'h0000_0000;
      if (rd_map) begin
        case (rd_idx)
          `DMACE_IDX_PRIO_EN: rdata_q[15:0] <= {2'h0, pri_q, 2'h0, en_q};
          `DMACE_IDX_INDEX:   rdata_q[15:0] <= index_q;
          `DMACE_IDX_STATUS:  rdata_q[15:0] <= {2'h0, err_q, st_q != DMACE_IDLE, 4'h0, cur_q};
          default: begin
            if (rd_idx >= `DMACE_IDX_CH_BASE) begin
              case (rd_idx[1:0])
                2'h0:    rdata_q[15:0] <= src_all[16*(rd_idx[4:2] - 3'h2) +: 16];
                2'h1:    rdata_q[15:0] <= dst_all[16*(rd_idx[4:2] - 3'h2) +: 16];
                2'h2:    rdata_q[15:0] <= {8'h00, mode_all[8*(rd_idx[4:2] - 3'h2) +: 8]};
                default: rdata_q[15:0] <= cnt_all[16*(rd_idx[4:2] - 3'h2) +: 16];
              endcase
            end
          end
        endcase
      end
    end else if (axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- per-channel context ----------------
  for (genvar c = 0; c < `DMACE_NCH; c++) begin : g_ch
    logic [15:0] src_q;
    logic [15:0] dst_q;
    logic [7:0]  mode_q;
    logic [15:0] cnt_q;
    logic        wsel;
    logic        stp;
    assign wsel = wr_fire && wr_map && (wr_idx[7:2] == 6'(int'(`DMACE_IDX_CH_BASE) / 4 + c));
    assign stp  = step_ok && (cur_q == 3'(c));
    assign src_all[16*c +: 16] = src_q;
    assign dst_all[16*c +: 16] = dst_q;
    assign mode_all[8*c +: 8]  = mode_q;
    assign cnt_all[16*c +: 16] = cnt_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        src_q  <= `DMACE_RST16;
        dst_q  <= `DMACE_RST16;
        mode_q <= 8'h00;
        cnt_q  <= `DMACE_RST16;
      end else if (wsel) begin
        case (wr_idx[1:0])
          2'h0:    src_q  <= wmask(src_q, w_data_q, w_strb_q);
          2'h1:    dst_q  <= wmask(dst_q, w_data_q, w_strb_q);
          2'h2:    mode_q <= w_strb_q[0] ? w_data_q[7:0] : mode_q;
          default: cnt_q  <= wmask(cnt_q, w_data_q, w_strb_q);
        endcase
      end else if (stp) begin
        src_q <= next_addr(src_q, mode_q[1:0], index_q);
        dst_q <= next_addr(dst_q, mode_q[3:2], index_q);
        if (cnt_q != 16'h0000) begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end

  // ---------------- enable, priority, index ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 6'h00;
    end else begin
      for (int i = 0; i < `DMACE_NCH; i++) begin
        if (sc_wr && w_data_q[i]) begin
          en_q[i] <= w_data_q[`DMACE_SC_SET_BIT];
        end else if (pe_wr && w_strb_q[0]) begin
          en_q[i] <= w_data_q[i] && !done_clr[i];
        end else if (done_clr[i]) begin
          en_q[i] <= 1'b0;
        end
      end
    end
  end
  // unselected channels and bits 14..6 fall through untouched

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_q <= 6'h00;
    end else if (pe_wr && w_strb_q[1]) begin
      pri_q <= w_data_q[`DMACE_PRI_LSB +: 6];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_q <= `DMACE_RST16;
    end else if (wr_fire && wr_map && wr_idx == `DMACE_IDX_INDEX) begin
      index_q <= wmask(index_q, w_data_q, w_strb_q);
    end
  end

  // sticky map errors, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 6'h00;
    end else begin
      err_q <= (err_q & ~((wr_fire && wr_map && wr_idx == `DMACE_IDX_STATUS && w_strb_q[1])
                          ? w_data_q[13:8] : 6'h00)) | err_set;
    end
  end

  // ---------------- arbiter ----------------
  assign pick_hi = rr_pick(en_q & pri_q, ptr_hi_q);
  assign pick_lo = rr_pick(en_q & ~pri_q, ptr_lo_q);
  assign pick    = pick_hi[3] ? pick_hi : pick_lo;
  assign g_src   = src_all[16*pick[2:0] +: 16];
  assign g_dst   = dst_all[16*pick[2:0] +: 16];
  assign g_mode  = mode_all[8*pick[2:0] +: 8];
  assign g_src_ok = map_ok(g_src, g_mode[`DMACE_MD_SRC_EXT], g_mode[`DMACE_MD_SRC_IO]);
  assign g_dst_ok = map_ok(g_dst, g_mode[`DMACE_MD_DST_EXT], g_mode[`DMACE_MD_DST_IO]);

  assign step_ok  = (st_q == DMACE_STEP) && !bad_q;
  always_comb begin
    done_clr = 6'h00;
    err_set  = 6'h00;
    if (st_q == DMACE_STEP) begin
      if (bad_q) begin
        done_clr[cur_q] = 1'b1;
        err_set[cur_q]  = 1'b1;
      end else if (cnt_all[16*cur_q +: 16] == 16'h0000) begin
        done_clr[cur_q] = 1'b1;
      end
    end
  end
  assign chan_done  = done_clr & ~err_set;
  assign xfer_valid = (st_q == DMACE_ISSUE);
  assign xfer       = xfer_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= DMACE_IDLE;
      cur_q    <= 3'h0;
      bad_q    <= 1'b0;
      ptr_hi_q <= 3'h0;
      ptr_lo_q <= 3'h0;
      xfer_q   <= '0;
    end else begin
      case (st_q)
        DMACE_IDLE: begin
          if (pick[3]) begin
            cur_q           <= pick[2:0];
            bad_q           <= !(g_src_ok && g_dst_ok);
            xfer_q.chan     <= pick[2:0];
            xfer_q.src_addr <= g_src;
            xfer_q.dst_addr <= g_dst;
            xfer_q.src_ext  <= g_mode[`DMACE_MD_SRC_EXT];
            xfer_q.dst_ext  <= g_mode[`DMACE_MD_DST_EXT];
            xfer_q.src_blk  <= g_src[14:13];
            xfer_q.dst_blk  <= g_dst[14:13];
            st_q            <= (g_src_ok && g_dst_ok) ? DMACE_ISSUE : DMACE_STEP;
            if (pick_hi[3]) begin
              ptr_hi_q <= (pick[2:0] == 3'h5) ? 3'h0 : pick[2:0] + 3'h1;
            end else begin
              ptr_lo_q <= (pick[2:0] == 3'h5) ? 3'h0 : pick[2:0] + 3'h1;
            end
          end
        end
        DMACE_ISSUE: begin
          if (xfer_ready) begin
            st_q <= DMACE_STEP;
          end
        end
        DMACE_STEP: begin
          st_q <= DMACE_IDLE;
        end
        default: begin
          st_q <= DMACE_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/dmace_top_checker.sv
// Purpose: concurrent checks on dmace_top ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every dmace_top instance
`timescale 1ns/10ps
`default_nettype none
`include "dmace_consts.svh"
module dmace_checker
  import dmace_pkg::*;
(
  input wire logic                       aclk,       // clock
  input wire logic                       aresetn,    // reset, low
  input wire dmace_pkg::dmace_axil_req_s axil_req,   // bus requests
  input wire dmace_pkg::dmace_axil_rsp_s axil_rsp,   // bus answers
  input wire logic                       xfer_valid, // element offered
  input wire logic                       xfer_ready, // element taken
  input wire dmace_pkg::dmace_xfer_s     xfer,       // element addresses
  input wire logic [5:0]                 chan_done   // block complete
);
  logic       taken_q;
  logic [2:0] chan_q;
  wire        wr_both;
  assign wr_both = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  // last handshake and its channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_q <= 1'b0;
      chan_q  <= 3'h0;
    end else begin
      taken_q <= xfer_valid && xfer_ready;
      chan_q  <= xfer.chan;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take;
    xfer_valid && xfer_ready;
  endsequence
  sequence s_gap;
    !xfer_valid [*2];
  endsequence
  a_xfer_hold: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer))
    else $error("element changed before taken");
  a_elem_gap: assert property (s_take |=> s_gap)
    else $error("element offered too soon");
  a_done_onehot: assert property (chan_done != 6'h00 |-> $onehot(chan_done))
    else $error("several completions at once");
  a_done_cause: assert property (chan_done != 6'h00 |-> taken_q && chan_done == (6'h01 << chan_q))
    else $error("completion without its element");
  a_src_map: assert property (xfer_valid && !xfer.src_ext |-> xfer.src_addr inside {[16'h0080:16'h7FFF]})
    else $error("internal source outside ram");
  a_dst_map: assert property (xfer_valid && !xfer.dst_ext |-> xfer.dst_addr inside {[16'h0080:16'h7FFF]})
    else $error("internal target outside ram");
  a_blk_field: assert property (xfer_valid && !xfer.src_ext && !xfer.dst_ext |->
    xfer.src_blk == xfer.src_addr[14:13] && xfer.dst_blk == xfer.dst_addr[14:13])
    else $error("ram block field wrong");
  a_setclr_read: assert property (axil_req.arvalid && axil_rsp.arready && axil_req.araddr == 12'h0F8
    |=> axil_rsp.rvalid && axil_rsp.rdata == 32'h0000_0000)
    else $error("set clear register read not zero");
  a_unmapped_err: assert property (axil_req.arvalid && axil_rsp.arready && axil_req.araddr[11:10] != 2'h0
    |=> axil_rsp.rvalid && axil_rsp.rresp == `DMACE_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_write_resp: assert property (wr_both && !axil_rsp.bvalid |-> ##2 axil_rsp.bvalid)
    else $error("write answer late");
endmodule
bind dmace_top dmace_checker u_chk (
  .aclk       (aclk),
  .aresetn    (aresetn),
  .axil_req   (axil_req),
  .axil_rsp   (axil_rsp),
  .xfer_valid (xfer_valid),
  .xfer_ready (xfer_ready),
  .xfer       (xfer),
  .chan_done  (chan_done)
);
`default_nettype wire

//--- tb/tb_dmace_top.sv
// Purpose: self-checking bench for dmace_top
// Assumes: AXI4-Lite byte address is four times the register index
// Notes:   count 0 means one element per block
`timescale 1ns/10ps
`default_nettype none
module tb_dmace_top;
  import dmace_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic            aclk;
  logic            aresetn;
  dmace_axil_req_s req;
  dmace_axil_rsp_s rsp;
  logic            xfer_valid;
  logic            xfer_ready;
  dmace_xfer_s     xfer;
  logic [5:0]      chan_done;
  int              fail_count = 0;
  int              n_checks = 0;
  int              cyc = 0;
  int              ndone = 0;
  int              d0;
  logic [2:0]      qc[$];
  logic [15:0]     qs[$];
  logic [15:0]     qd[$];
  logic            qx[$];
  logic [31:0]     rd;
  logic [1:0]      rs;
  dmace_top dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer(xfer), .chan_done(chan_done));
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  // negedge sees what the next rising edge samples
  always @(negedge aclk) begin
    if (xfer_valid && xfer_ready) begin
      qc.push_back(xfer.chan);
      qs.push_back(xfer.src_addr);
      qd.push_back(xfer.dst_addr);
      qx.push_back(xfer.src_ext);
    end
    ndone += $countones(chan_done);
  end
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = req.awvalid && rsp.awready;
      w_t  = req.wvalid && rsp.wready;
      b_t  = rsp.bvalid;
      r    = rsp.bresp;
      @(posedge aclk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (b_t) req.bready <= 1'b0;
    end
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = req.arvalid && rsp.arready;
      r_t  = rsp.rvalid;
      d    = rsp.rdata;
      r    = rsp.rresp;
      @(posedge aclk);
      if (ar_t) req.arvalid <= 1'b0;
      if (r_t) req.rready <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    `CHK(r, 2'h0)
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    `CHK(d, e)
  endtask
  task automatic cfg(input int c, input logic [15:0] s, input logic [15:0] t,
                     input logic [31:0] m, input logic [31:0] n);
    logic [11:0] b;
    b = 12'h120 + 12'(c * 16);
    wr(b, {16'h0000, s});
    wr(b + 12'h004, {16'h0000, t});
    wr(b + 12'h008, m);
    wr(b + 12'h00C, n);
  endtask
  // polls until no channel enabled and engine idle
  task automatic wait_idle();
    logic [31:0] en, st;
    logic [1:0]  r;
    en = 32'hFFFF_FFFF;
    st = 32'hFFFF_FFFF;
    for (int i = 0; i < 60 && (st[7] || en[5:0] != 6'h00); i++) begin
      axr(12'h100, en, r);
      axr(12'h108, st, r);
    end
    `CHK({st[7], en[5:0]}, 7'h00)
  endtask
  task automatic start();
    qc.delete();
    qs.delete();
    qd.delete();
    qx.delete();
    d0 = ndone;
  endtask
  function automatic logic [2:0] nxt(input logic [2:0] c);
    nxt = (c == 3'h0) ? 3'h2 : (c == 3'h5) ? 3'h0 : c + 3'h1;
  endfunction
  initial begin
    aresetn    = 1'b0;
    req        = '0;
    xfer_ready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(12'h0F8, 32'h0000_0000);
    rchk(12'h100, 32'h0000_0000);
    rchk(12'h108, 32'h0000_0000);
    $display("test reset done");
    for (int c = 0; c < 6; c++) cfg(c, 16'h1000 + 16'(c), 16'h6000 + 16'(c), 32'h05, 32'h0);
    wr(12'h0F8, 32'h0000_8001);
    rchk(12'h100, 32'h0000_0001);
    wr(12'h0F8, 32'h0000_C06C);
    rchk(12'h100, 32'h0000_002D);
    wr(12'h0F8, 32'h0000_0022);
    rchk(12'h100, 32'h0000_000D);
    wr(12'h0F8, 32'h0000_8000);
    rchk(12'h100, 32'h0000_000D);
    axw(12'h0FC, 32'h0000_803F, rs);
    `CHK(rs, 2'h2)
    rchk(12'h100, 32'h0000_000D);
    axr(12'hFFC, rd, rs);
    `CHK(rs, 2'h2)
    rchk(12'h0F8, 32'h0000_0000);
    start();
    xfer_ready <= 1'b1;
    wait_idle();
    `CHK({qc[0], qc[1], qc[2]}, 9'h013)
    `CHK(ndone - d0, 3)
    $display("test set clear done");
    xfer_ready <= 1'b0;
    wr(12'h100, 32'h0000_0200);
    wr(12'h0F8, 32'h0000_803F);
    rchk(12'h100, 32'h0000_023F);
    start();
    xfer_ready <= 1'b1;
    wait_idle();
    `CHK(qc.size(), 6)
    `CHK(qc[0], 3'h1)
    for (int i = 1; i < 5; i++) `CHK(qc[i + 1], nxt(qc[i]))
    `CHK(ndone - d0, 6)
    rchk(12'h100, 32'h0000_0200);
    $display("test priority done");
    wr(12'h100, 32'h0000_0000);
    wr(12'h104, 32'h0000_0010);
    cfg(2, 16'h0100, 16'h0200, 32'h09, 32'h1);
    cfg(3, 16'h0300, 16'h0400, 32'h03, 32'h1);
    start();
    wr(12'h0F8, 32'h0000_800C);
    wait_idle();
    `CHK({qc[0] != qc[1], qc[2] == qc[0], qc[3] == qc[1]}, 3'h7)
    for (int i = 0; i < 4; i++) `CHK({qs[i], qd[i]}, (qc[i] == 3'h2) ?
      {16'h0100 + 16'(i / 2), 16'h0200 - 16'(i / 2)} : {16'h0300 + 16'(16 * (i / 2)), 16'h0400})
    `CHK(ndone - d0, 2)
    $display("test stepping done");
    cfg(0, 16'h8000, 16'h1000, 32'h05, 32'h0);
    cfg(1, 16'h8000, 16'h1000, 32'h45, 32'h0);
    cfg(2, 16'h1000, 16'h1000, 32'h25, 32'h0);
    start();
    wr(12'h0F8, 32'h0000_8007);
    wait_idle();
    `CHK({qc.size() == 1, qc[0], qx[0]}, 5'h13)
    axr(12'h108, rd, rs);
    `CHK(rd & 32'h0000_3F00, 32'h0000_0500)
    `CHK(ndone - d0, 1)
    $display("test memory map done");
    xfer_ready <= 1'b0;
    cfg(4, 16'h1000, 16'h2000, 32'h05, 32'h0);
    cfg(5, 16'h1000, 16'h2000, 32'h05, 32'h0);
    wr(12'h0F8, 32'h0000_8010);
    start();
    // ready and the write land so that completion and write meet in one cycle
    fork
      axw(12'h0F8, 32'h0000_8020, rs);
      begin
        @(posedge aclk);
        xfer_ready <= 1'b1;
      end
    join
    `CHK(rs, 2'h0)
    wait_idle();
    `CHK({qc.size() == 2, qc[0], qc[1]}, 7'h65)
    `CHK(ndone - d0, 2)
    $display("test collision done");
    wrap_up();
  end
endmodule
`default_nettype wire
